//--- logic/spc_top.sv
// sleep-pin clamp control: registers, Avalon-MM slave and clamp outputs
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
module spc_top
    import spc_pkg::*;
#(
    parameter int NUM_CONV = SPC_NUM_CONV
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [SPC_ADDR_W+1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [SPC_DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [SPC_DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic second_sleep_pin_i,
    output logic amp_enable_pin_o,
    output logic [NUM_CONV-1:0] conv_clamp_o,
    output logic [SPC_REG_W-1:0] alarm_output_clamp_o
);
    spc_bus_req_type req;
    spc_bus_state_type bus_state_r;
    logic [SPC_REG_W-1:0] sleep_cfg_r;
    logic [SPC_REG_W-1:0] alarm_clamp_r;
    logic [SPC_REG_W-1:0] amp_enable_r;
    logic [SPC_REG_W-1:0] clamp_cfg_r;
    logic [SPC_DATA_W-1:0] readdata_r;
    logic waitrequest_r;
    logic amp_pin_r;
    logic [NUM_CONV-1:0] conv_clamp_r;
    logic sleep_sync;
    logic amp_held;
    logic [NUM_CONV-1:0] conv_held;
    logic take;
    logic wr_amp;
    logic wr_clamp;
    logic [SPC_DATA_W-1:0] rd_mux;

    // merge a write word into a 16-bit register by byte lanes
    function automatic logic [SPC_REG_W-1:0] merge16(
        input logic [SPC_REG_W-1:0] old,
        input logic [SPC_DATA_W-1:0] wdata,
        input logic [3:0] be
    );
        logic [SPC_REG_W-1:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction

    function automatic logic [SPC_DATA_W-1:0] zext16(input logic [SPC_REG_W-1:0] v);
        return {{(SPC_DATA_W-SPC_REG_W){1'b0}}, v};
    endfunction

    assign req.address = avs_address_i[SPC_ADDR_W+1:2];
    assign req.read = avs_read_i;
    assign req.write = avs_write_i;
    assign req.writedata = avs_writedata_i;
    assign req.byteenable = avs_byteenable_i;

    // answer one cycle after a request is seen, to keep read data registered
    assign take = (bus_state_r == SPC_BUS_ACK);
    assign wr_amp = take && req.write && (req.address == SPC_IDX_AMP_ENABLE);
    assign wr_clamp = take && req.write && (req.address == SPC_IDX_CLAMP_CFG);

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            bus_state_r <= SPC_BUS_IDLE;
            waitrequest_r <= 1'b1;
        end else begin
            case (bus_state_r)
                SPC_BUS_IDLE: begin
                    if (req.read || req.write) begin
                        bus_state_r <= SPC_BUS_ACK;
                        waitrequest_r <= 1'b0;
                    end
                end
                SPC_BUS_ACK: begin
                    bus_state_r <= SPC_BUS_IDLE;
                    waitrequest_r <= 1'b1;
                end
                default: begin
                    bus_state_r <= SPC_BUS_IDLE;
                    waitrequest_r <= 1'b1;
                end
            endcase
        end
    end

    always_comb begin
        if (req.address == SPC_IDX_SECOND_SLEEP_PIN_CFG) begin
            rd_mux = zext16(sleep_cfg_r);
        end else if (req.address == SPC_IDX_ALARM_CLAMP) begin
            rd_mux = zext16(alarm_clamp_r);
        end else if (req.address == SPC_IDX_AMP_ENABLE) begin
            rd_mux = zext16(amp_enable_r);
        end else if (req.address == SPC_IDX_CLAMP_CFG) begin
            rd_mux = zext16(clamp_cfg_r);
        end else if (req.address == SPC_IDX_STATUS) begin
            rd_mux = SPC_UNMAPPED_READ;
            rd_mux[NUM_CONV-1:0] = conv_clamp_r;
            rd_mux[SPC_FLD_STAT_AMP] = amp_pin_r;
            rd_mux[SPC_FLD_STAT_SLEEP] = sleep_sync;
        end else begin
            rd_mux = SPC_UNMAPPED_READ;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            readdata_r <= SPC_UNMAPPED_READ;
        end else if ((bus_state_r == SPC_BUS_IDLE) && req.read) begin
            readdata_r <= rd_mux;
        end
    end

    // reserved bits are plain storage; keeping them is the host's job
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            sleep_cfg_r <= SPC_RST_SECOND_SLEEP_PIN_CFG;
        end else if (take && req.write && (req.address == SPC_IDX_SECOND_SLEEP_PIN_CFG)) begin
            sleep_cfg_r <= merge16(sleep_cfg_r, req.writedata, req.byteenable);
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            alarm_clamp_r <= SPC_RST_ALARM_CLAMP;
        end else if (take && req.write && (req.address == SPC_IDX_ALARM_CLAMP)) begin
            alarm_clamp_r <= merge16(alarm_clamp_r, req.writedata, req.byteenable);
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            amp_enable_r <= SPC_RST_AMP_ENABLE;
        end else if (wr_amp) begin
            amp_enable_r <= merge16(amp_enable_r, req.writedata, req.byteenable);
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            clamp_cfg_r <= SPC_RST_CLAMP_CFG;
        end else if (wr_clamp) begin
            clamp_cfg_r <= merge16(clamp_cfg_r, req.writedata, req.byteenable);
        end
    end

    spc_sync u_sync (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .async_i(second_sleep_pin_i),
        .sync_o(sleep_sync)
    );

    // the pin high keeps the hold set, so a release write to the amp enable register cannot wake early
    spc_clamp_ch u_amp_ch (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .sleep_i(sleep_sync),
        .sleep_en_i(sleep_cfg_r[SPC_FLD_AMP_SLEEP]),
        .wake_hold_i(sleep_cfg_r[SPC_FLD_AMP_HOLD]),
        .release_i(wr_amp),
        .held_o(amp_held)
    );

    genvar g;
    generate
        for (g = 0; g < NUM_CONV; g++) begin : g_conv
            spc_clamp_ch u_conv_ch (
                .clock_i(clock_i),
                .srst_i(srst_i),
                .sleep_i(sleep_sync),
                .sleep_en_i(sleep_cfg_r[SPC_FLD_CONV_SLEEP_LSB + g]),
                .wake_hold_i(sleep_cfg_r[SPC_FLD_CONV_HOLD_LSB + g]),
                .release_i(wr_clamp),
                .held_o(conv_held[g])
            );
        end
    endgenerate

    // outputs: software level, forced off or into clamp while held
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            amp_pin_r <= 1'b0;
            conv_clamp_r <= '0;
        end else begin
            amp_pin_r <= amp_enable_r[SPC_FLD_AMP_ON] && !amp_held;
            conv_clamp_r <= clamp_cfg_r[NUM_CONV-1:0] | conv_held;
        end
    end

    assign avs_readdata_o = readdata_r;
    assign avs_waitrequest_o = waitrequest_r;
    assign amp_enable_pin_o = amp_pin_r;
    assign conv_clamp_o = conv_clamp_r;
    assign alarm_output_clamp_o = alarm_clamp_r;
endmodule

//--- logic/spc_pkg.sv
// package: register map, field layout and carrier types for the sleep-pin clamp block
package spc_pkg;
    localparam int SPC_ADDR_W = 8;
    localparam int SPC_DATA_W = 32;
    localparam int SPC_REG_W = 16;
    localparam int SPC_NUM_CONV = 6;
    // printed offsets are word indexes, byte address is four times the index
    localparam logic [SPC_ADDR_W-1:0] SPC_IDX_SECOND_SLEEP_PIN_CFG = 8'h19;
    localparam logic [SPC_ADDR_W-1:0] SPC_IDX_ALARM_CLAMP = 8'h1A;
    localparam logic [SPC_ADDR_W-1:0] SPC_IDX_AMP_ENABLE = 8'h1C;
    localparam logic [SPC_ADDR_W-1:0] SPC_IDX_CLAMP_CFG = 8'h1D;
    localparam logic [SPC_ADDR_W-1:0] SPC_IDX_STATUS = 8'h1E;
    localparam logic [SPC_REG_W-1:0] SPC_RST_SECOND_SLEEP_PIN_CFG = 16'hFF00;
    localparam logic [SPC_REG_W-1:0] SPC_RST_ALARM_CLAMP = 16'h0000;
    localparam logic [SPC_REG_W-1:0] SPC_RST_AMP_ENABLE = 16'h0000;
    localparam logic [SPC_REG_W-1:0] SPC_RST_CLAMP_CFG = 16'h0000;
    localparam logic [SPC_DATA_W-1:0] SPC_UNMAPPED_READ = 32'h0000_0000;
    localparam int SPC_FLD_CONV_SLEEP_LSB = 0;
    localparam int SPC_FLD_AMP_SLEEP = 6;
    localparam int SPC_FLD_CONV_HOLD_LSB = 8;
    localparam int SPC_FLD_AMP_HOLD = 14;
    localparam int SPC_FLD_AMP_ON = 0;
    localparam int SPC_FLD_STAT_AMP = 8;
    localparam int SPC_FLD_STAT_SLEEP = 9;
    localparam int SPC_SYNC_STAGES = 2;

    typedef struct packed {
        logic [SPC_ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [SPC_DATA_W-1:0] writedata;
        logic [3:0] byteenable;
    } spc_bus_req_type;

    typedef struct packed {
        logic [SPC_DATA_W-1:0] readdata;
        logic waitrequest;
    } spc_bus_rsp_type;

    typedef enum logic [1:0] {
        SPC_BUS_IDLE,
        SPC_BUS_ACK
    } spc_bus_state_type;
endpackage

//--- logic/spc_sync.sv
// two-flop synchroniser for the asynchronous sleep pin
`timescale 1ns/1ps
module spc_sync
    import spc_pkg::*;
#(
    parameter int STAGES = SPC_SYNC_STAGES
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic async_i,
    output logic sync_o
);
    logic [STAGES-1:0] chain_r;

    // first stage is read only by the next stage
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            chain_r <= '0;
        end else begin
            chain_r <= {chain_r[STAGES-2:0], async_i};
        end
    end

    assign sync_o = chain_r[STAGES-1];
endmodule

//--- logic/spc_clamp_ch.sv
// one clamp channel: sleep enable, wake hold and software release
`timescale 1ns/1ps
module spc_clamp_ch (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic sleep_i,
    input wire logic sleep_en_i,
    input wire logic wake_hold_i,
    input wire logic release_i,
    output logic held_o
);
    logic held_r;

    // a high pin wins over a software release in the same cycle while sleep_en_i is set
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            held_r <= 1'b0;
        end else if (sleep_en_i && sleep_i) begin
            held_r <= 1'b1;
        end else if (!sleep_en_i) begin
            held_r <= 1'b0;
        end else if (!wake_hold_i || release_i) begin
            held_r <= 1'b0;
        end
    end

    assign held_o = held_r;
endmodule

//--- verification/spc_top_properties.sv
// checker: port properties of the sleep-pin clamp block
`timescale 1ns/1ps
module spc_top_properties
    import spc_pkg::*;
#(
    parameter int NUM_CONV = SPC_NUM_CONV
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [SPC_DATA_W-1:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic second_sleep_pin_i,
    input wire logic amp_enable_pin_o,
    input wire logic [NUM_CONV-1:0] conv_clamp_o,
    input wire logic [SPC_REG_W-1:0] alarm_output_clamp_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);
    a_wait_one_low:
        assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("wait low too long");
    a_idle_no_ack:
        assert property (!$past(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
        else $error("ack without request");
    a_req_gets_ack:
        assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |-> ##[1:2] !avs_waitrequest_o)
        else $error("request not answered");
    a_rdata_upper:
        assert property (!avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000)
        else $error("read data upper half set");
    // writes may legally move outputs, so only quiet spans are judged
    a_amp_stays_off:
        assert property (second_sleep_pin_i [*6] |-> !$rose(amp_enable_pin_o)
            || $past(avs_write_i) || $past(avs_write_i, 2))
        else $error("amp on while pin high");
    a_clamp_stays:
        assert property (second_sleep_pin_i [*6] |-> (($past(conv_clamp_o) & ~conv_clamp_o) == '0)
            || $past(avs_write_i) || $past(avs_write_i, 2))
        else $error("clamp left while pin high");
    a_clamp_needs_pin:
        assert property (!second_sleep_pin_i [*6] |-> ((conv_clamp_o & ~$past(conv_clamp_o)) == '0)
            || $past(avs_write_i) || $past(avs_write_i, 2))
        else $error("clamp without pin or write");
    a_alarm_by_write:
        assert property (!$past(avs_write_i) && !$past(avs_write_i, 2)
            |-> $stable(alarm_output_clamp_o))
        else $error("alarm clamp moved without write");
endmodule
bind spc_top spc_top_properties #(.NUM_CONV(NUM_CONV)) i_props (
    .clock_i(clock_i), .srst_i(srst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .second_sleep_pin_i(second_sleep_pin_i), .amp_enable_pin_o(amp_enable_pin_o),
    .conv_clamp_o(conv_clamp_o), .alarm_output_clamp_o(alarm_output_clamp_o));

//--- verification/spc_host_model.sv
// host model: bus master and sleep pin driver
`timescale 1ns/1ps
module spc_host_model
    import spc_pkg::*;
(
    input wire logic clock_i,
    input wire spc_bus_rsp_type rsp_i,
    output spc_bus_req_type req_o,
    output logic second_sleep_pin_o
);
    initial begin
        req_o = '{address: 8'h00, read: 1'b0, write: 1'b0, writedata: 32'h0, byteenable: 4'hF};
        second_sleep_pin_o = 1'b0;
    end
    function automatic logic [15:0] keep_rsvd(input logic [15:0] d);
        return (d & 16'h7F7F) | 16'h8000;
    endfunction
    // released address and write data show inverted values so stale data cannot pass; byteenable stays 4'hF
    task automatic access(input logic wr, input logic [7:0] idx, input logic [15:0] d,
            output logic [31:0] q);
        @(posedge clock_i);
        req_o <= '{address: idx, read: !wr, write: wr, writedata: {16'h0, d}, byteenable: 4'hF};
        do @(posedge clock_i); while (rsp_i.waitrequest !== 1'b0);
        q = rsp_i.readdata;
        req_o <= '{address: ~idx, read: 1'b0, write: 1'b0, writedata: ~{16'h0, d},
            byteenable: 4'hF};
    endtask
    task automatic set_pin(input logic v);
        @(posedge clock_i);
        second_sleep_pin_o <= v;
    endtask
endmodule

//--- verification/sleep_pin_clamp_control_tb_top.sv
// self-checking bench for the sleep-pin clamp block
`timescale 1ns/1ps
module sleep_pin_clamp_control_tb_top
    import spc_pkg::*;
;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    spc_bus_req_type req;
    spc_bus_rsp_type rsp;
    logic [31:0] rdata;
    logic wait_req;
    logic pin;
    logic amp;
    logic [5:0] clamp;
    logic [15:0] alarm;
    int num_errors = 0;
    int checks_done = 0;
    always #50 clock_i = ~clock_i;
    // one driver per member: the slave's two outputs fill the response word
    assign rsp = '{readdata: rdata, waitrequest: wait_req};
    spc_host_model i_host (.clock_i(clock_i), .rsp_i(rsp), .req_o(req), .second_sleep_pin_o(pin));
    spc_top i_dut (.clock_i(clock_i), .srst_i(srst_i), .avs_address_i({req.address, 2'b00}),
        .avs_read_i(req.read), .avs_write_i(req.write), .avs_writedata_i(req.writedata),
        .avs_byteenable_i(req.byteenable), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_req), .second_sleep_pin_i(pin),
        .amp_enable_pin_o(amp), .conv_clamp_o(clamp), .alarm_output_clamp_o(alarm));
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic report(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [7:0] idx, input logic [15:0] exp);
        logic [31:0] q;
        i_host.access(1'b0, idx, 16'h0, q);
        report(q, {16'h0, exp});
    endtask
    task automatic chk_pins(input logic [6:0] exp);
        report({25'h0, amp, clamp}, {25'h0, exp});
    endtask
    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        logic [31:0] q;
        i_host.access(1'b1, idx, d, q);
    endtask
    // amp bit on top, clamp bits below; held state only after the pin falls
    function automatic logic [6:0] pins_exp(input logic [15:0] c, input logic asleep);
        if (asleep) begin
            return {~c[6], c[5:0]};
        end
        return {~(c[6] & c[14]), c[5:0] & c[13:8]};
    endfunction
    initial begin
        #2000000;
        num_errors++;
        complete_run();
    end
    initial begin
        logic [15:0] cfg;
        void'($urandom(32'h5C687992));
        repeat (6) @(posedge clock_i);
        srst_i <= 1'b0;
        chk_reg(SPC_IDX_SECOND_SLEEP_PIN_CFG, 16'hFF00);
        chk_reg(SPC_IDX_ALARM_CLAMP, 16'h0000);
        wr(8'h05, 16'hFFFF);
        chk_reg(8'h05, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            cfg = i_host.keep_rsvd(16'($urandom()));
            wr(SPC_IDX_ALARM_CLAMP, ~cfg);
            wr(SPC_IDX_SECOND_SLEEP_PIN_CFG, cfg);
            chk_reg(SPC_IDX_SECOND_SLEEP_PIN_CFG, cfg);
            chk_reg(SPC_IDX_ALARM_CLAMP, ~cfg);
            report({16'h0, alarm}, {16'h0, ~cfg});
        end
        for (int i = 0; i < 10; i++) begin
            cfg = (i == 0) ? 16'hFF7F : (i == 1) ? 16'h807F : (i == 2) ? 16'h8000
                : i_host.keep_rsvd(16'($urandom()));
            wr(SPC_IDX_AMP_ENABLE, 16'h0001);
            wr(SPC_IDX_CLAMP_CFG, 16'h0000);
            wr(SPC_IDX_SECOND_SLEEP_PIN_CFG, cfg);
            repeat (2) @(posedge clock_i);
            chk_pins(7'h40);
            i_host.set_pin(1'b1);
            repeat (6) @(posedge clock_i);
            chk_pins(pins_exp(cfg, 1'b1));
            chk_reg(SPC_IDX_STATUS, {6'h0, 1'b1, ~cfg[6], 2'h0, cfg[5:0]});
            wr(SPC_IDX_AMP_ENABLE, 16'h0001);
            wr(SPC_IDX_CLAMP_CFG, 16'h0000);
            repeat (2) @(posedge clock_i);
            chk_pins(pins_exp(cfg, 1'b1));
            i_host.set_pin(1'b0);
            repeat (6) @(posedge clock_i);
            chk_pins(pins_exp(cfg, 1'b0));
            wr(SPC_IDX_AMP_ENABLE, 16'h0001);
            wr(SPC_IDX_CLAMP_CFG, 16'h0000);
            repeat (2) @(posedge clock_i);
            chk_pins(7'h40);
        end
        complete_run();
    end
endmodule
